// >>> logic/clie_pkg.sv
// Constants and types for the character display instruction executor
package clie_pkg;
  // Address pointer and glyph address widths
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned GLYPH_W = 6;
  // Line layout limits for two-line and one-line modes
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
  // Pan offset wraps on a 40-column line
  localparam logic [5:0] PAN_LAST = 6'h27;
  // Reset values of mode bits
  localparam logic RST_STEP_UP = 1'b1;
  localparam logic RST_AUTO_PAN = 1'b0;
  localparam logic RST_BUS_8BIT = 1'b1;
  localparam logic RST_TWO_LINE = 1'b0;
  localparam logic RST_FONT_TALL = 1'b0;
  // Execution time per instruction, 18.5 us at a 25 ns clock
  localparam int unsigned EXEC_NS = 18500;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned EXEC_CYC = EXEC_NS / CLK_NS;
  // Flash half period: 185 ms at 540 kHz equals 99900 oscillator cycles
  localparam int unsigned FLASH_OSC_CYC = 99900;
  // Display duty codes
  typedef enum logic [1:0] {CLIE_DUTY_8, CLIE_DUTY_11, CLIE_DUTY_16} clie_duty_t;
  typedef enum logic [0:0] {CLIE_IDLE, CLIE_BUSY} clie_state_t;
endpackage

// >>> logic/clie_exec.sv
// Instruction decoder and executor for a character display controller
`timescale 1ns/1ps
`default_nettype none
module clie_exec
  import clie_pkg::*;
#(
  parameter int unsigned EXEC_CYCLES = EXEC_CYC,
  parameter int unsigned FLASH_CYCLES = 2000000
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_strobe,
  input wire logic i_cmd_or_data_sel,
  input wire logic i_read,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_bus,
  output logic o_bus_oe,
  output logic o_busy_flag,
  output logic [6:0] o_address_pointer,
  output logic o_panel_on,
  output logic o_cursor_show,
  output logic o_cursor_lit,
  output logic [5:0] o_pan_offset,
  output logic o_bus_width_sel,
  output logic [1:0] o_duty,
  output logic o_ram_we,
  output logic o_ram_glyph,
  output logic [6:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  input wire logic [7:0] i_ram_rdata
);
  // =========================================================
  // Pointer stepping
  // Two-line wrap keeps the pointer inside the printed ranges
  function automatic logic [6:0] clie_step(input logic [6:0] a, input logic up,
                                           input logic two, input logic glyph);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (up && a == LINE1_LAST) r = LINE2_FIRST;
      else if (up && a == LINE2_LAST) r = 7'h00;
      else if (!up && a == LINE2_FIRST) r = LINE1_LAST;
      else if (!up && a == 7'h00) r = LINE2_LAST;
    end else begin
      if (up && a == ONE_LINE_LAST) r = 7'h00;
      else if (!up && a == 7'h00) r = ONE_LINE_LAST;
    end
    return r;
  endfunction
  function automatic logic [5:0] clie_pan(input logic [5:0] p, input logic left);
    if (left) return (p == PAN_LAST) ? 6'h00 : p + 6'h01;
    return (p == 6'h00) ? PAN_LAST : p - 6'h01;
  endfunction

  // =========================================================
  // State
  clie_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] fl_q, fl_d;
  logic flash_ph_q, flash_ph_d;
  logic [6:0] ap_q, ap_d;
  logic glyph_q, glyph_d;
  logic up_q, up_d, pan_en_q, pan_en_d;
  logic on_q, on_d, cur_q, cur_d, blink_q, blink_d;
  logic dl_q, dl_d, two_q, two_d, tall_q, tall_d;
  logic [5:0] pan_q, pan_d;
  logic [7:0] cmd_q, cmd_d, dat_q, dat_d, pre_q, pre_d;
  logic is_data_q, is_data_d, fetch2_q, fetch2_d;
  logic nib_q, nib_d;
  logic fetch_q, fetch_d;
  logic [7:0] ob_d;
  logic oe_d, we_d;
  logic [6:0] ra_d;
  logic [7:0] wd_d;
  logic [7:0] byte_in;
  logic byte_done;

  // Nibble assembly: upper first on lines 7..4
  always_comb begin
    byte_in = dl_q ? i_bus : {cmd_q[7:4], i_bus[7:4]};
    byte_done = i_strobe && (dl_q || nib_q);
  end

  // =========================================================
  // Next-state logic
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; ap_d = ap_q; glyph_d = glyph_q;
    up_d = up_q; pan_en_d = pan_en_q; on_d = on_q; cur_d = cur_q;
    blink_d = blink_q; dl_d = dl_q; two_d = two_q; tall_d = tall_q;
    pan_d = pan_q; cmd_d = cmd_q; dat_d = dat_q; pre_d = pre_q;
    is_data_d = is_data_q; nib_d = nib_q;
    fetch_d = 1'b0; we_d = 1'b0; ra_d = ap_q; wd_d = dat_q;
    ob_d = o_bus; oe_d = 1'b0;
    fl_d = fl_q; flash_ph_d = flash_ph_q;
    // Flash timer free-runs so phase is independent of commands
    if (fl_q >= FLASH_CYCLES - 1) begin
      fl_d = 32'd0;
      flash_ph_d = ~flash_ph_q;
    end else begin
      fl_d = fl_q + 32'd1;
    end
    // Sync RAM answers a cycle after it sees the registered address,
    // so the prefetch is taken from the second stage, not the first
    fetch2_d = fetch_q;
    if (fetch2_q) pre_d = i_ram_rdata;
    // Host reads answer at once, even while busy
    if (i_strobe && i_read) begin
      oe_d = 1'b1;
      if (!i_cmd_or_data_sel) ob_d = {st_q == CLIE_BUSY, ap_q};
      else ob_d = pre_q;
      nib_d = dl_q ? 1'b0 : ~nib_q;
      if (!dl_q && nib_q) ob_d = {ob_d[3:0], 4'h0};
      if (i_cmd_or_data_sel && (dl_q || nib_q)) begin
        ap_d = clie_step(ap_q, up_q, two_q, glyph_q);
        ra_d = ap_d;
        fetch_d = 1'b1;
      end
    end else if (i_strobe && st_q == CLIE_IDLE) begin
      // Writes accepted only when idle; host waits on busy
      nib_d = dl_q ? 1'b0 : ~nib_q;
      if (!nib_q) cmd_d = i_bus;
      if (byte_done) begin
        st_d = CLIE_BUSY;
        cnt_d = 32'd0;
        is_data_d = i_cmd_or_data_sel;
        if (i_cmd_or_data_sel) dat_d = byte_in;
        else cmd_d = byte_in;
      end
    end
    // Execution at the end of the busy time
    if (st_q == CLIE_BUSY) begin
      if (cnt_q >= EXEC_CYCLES - 1) begin
        st_d = CLIE_IDLE;
        if (is_data_q) begin
          we_d = 1'b1;
          ra_d = ap_q;
          wd_d = dat_q;
          ap_d = clie_step(ap_q, up_q, two_q, glyph_q);
          if (pan_en_q && !glyph_q) pan_d = clie_pan(pan_q, up_q);
        end else if (cmd_q[7]) begin
          ap_d = cmd_q[6:0]; glyph_d = 1'b0;
          ra_d = cmd_q[6:0]; fetch_d = 1'b1;
        end else if (cmd_q[6]) begin
          ap_d = {1'b0, cmd_q[5:0]}; glyph_d = 1'b1;
          ra_d = {1'b0, cmd_q[5:0]}; fetch_d = 1'b1;
        end else if (cmd_q[5]) begin
          dl_d = cmd_q[4]; two_d = cmd_q[3]; tall_d = cmd_q[2];
        end else if (cmd_q[4]) begin
          if (cmd_q[3]) begin
            // Pan after a glyph read is not guarded; the offset just steps
            pan_d = clie_pan(pan_q, !cmd_q[2]);
          end else begin
            ap_d = clie_step(ap_q, cmd_q[2], two_q, glyph_q);
            ra_d = ap_d; fetch_d = !glyph_q;
          end
        end else if (cmd_q[3]) begin
          on_d = cmd_q[2]; cur_d = cmd_q[1]; blink_d = cmd_q[0];
        end else if (cmd_q[2]) begin
          up_d = cmd_q[1]; pan_en_d = cmd_q[0];
        end
      end else begin
        cnt_d = cnt_q + 32'd1;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= CLIE_IDLE; cnt_q <= 32'd0; fl_q <= 32'd0; flash_ph_q <= 1'b0;
      ap_q <= 7'h00; glyph_q <= 1'b0; up_q <= RST_STEP_UP; pan_en_q <= RST_AUTO_PAN;
      on_q <= 1'b0; cur_q <= 1'b0; blink_q <= 1'b0; dl_q <= RST_BUS_8BIT;
      two_q <= RST_TWO_LINE; tall_q <= RST_FONT_TALL; pan_q <= 6'h00;
      cmd_q <= 8'h00; dat_q <= 8'h00; pre_q <= 8'h00; is_data_q <= 1'b0;
      fetch2_q <= 1'b0; nib_q <= 1'b0; fetch_q <= 1'b0;
      o_bus <= 8'h00; o_bus_oe <= 1'b0; o_ram_we <= 1'b0; o_ram_addr <= 7'h00;
      o_ram_wdata <= 8'h00;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; fl_q <= fl_d; flash_ph_q <= flash_ph_d;
      ap_q <= ap_d; glyph_q <= glyph_d; up_q <= up_d; pan_en_q <= pan_en_d;
      on_q <= on_d; cur_q <= cur_d; blink_q <= blink_d; dl_q <= dl_d;
      two_q <= two_d; tall_q <= tall_d; pan_q <= pan_d;
      cmd_q <= cmd_d; dat_q <= dat_d; pre_q <= pre_d; is_data_q <= is_data_d;
      fetch2_q <= fetch2_d; nib_q <= nib_d; fetch_q <= fetch_d;
      o_bus <= ob_d; o_bus_oe <= oe_d; o_ram_we <= we_d; o_ram_addr <= ra_d;
      o_ram_wdata <= wd_d;
    end
  end

  // =========================================================
  // Registered display outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy_flag <= 1'b0; o_address_pointer <= 7'h00; o_panel_on <= 1'b0;
      o_cursor_show <= 1'b0; o_cursor_lit <= 1'b0; o_pan_offset <= 6'h00;
      o_bus_width_sel <= RST_BUS_8BIT; o_duty <= CLIE_DUTY_8; o_ram_glyph <= 1'b0;
    end else begin
      o_busy_flag <= (st_d == CLIE_BUSY);
      o_address_pointer <= ap_d;
      o_panel_on <= on_d;
      o_cursor_show <= on_d && cur_d;
      o_cursor_lit <= on_d && blink_d && flash_ph_d;
      o_pan_offset <= pan_d;
      o_bus_width_sel <= dl_d;
      o_duty <= two_d ? CLIE_DUTY_16 : (tall_d ? CLIE_DUTY_11 : CLIE_DUTY_8);
      o_ram_glyph <= glyph_d;
    end
  end

  // =========================================================
  // Checks
  // A write that the idle executor takes in a single transfer
  sequence busy_start_s;
    i_strobe && !i_read && st_q == CLIE_IDLE && dl_q;
  endsequence
  busy_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    busy_start_s |=> o_busy_flag) else $error("busy not raised");
  busy_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    busy_start_s |=> o_busy_flag [*8]) else $error("busy dropped early");
  status_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_strobe && i_read && !i_cmd_or_data_sel && dl_q |=> o_bus_oe &&
    o_bus[6:0] == $past(ap_q)) else $error("status read wrong");
  status_busy_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_strobe && i_read && !i_cmd_or_data_sel && dl_q && st_q == CLIE_BUSY |=> o_bus[7])
    else $error("busy bit not shown");
  write_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_ram_we |-> o_ram_addr != ap_q) else $error("pointer not stepped");
  data_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_strobe && i_read && i_cmd_or_data_sel && dl_q |=> o_bus == $past(pre_q))
    else $error("prefetch not served");
  glyph_nopan_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_ram_we && o_ram_glyph |-> $stable(pan_q)) else $error("glyph access panned");
  cursor_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_panel_on |-> !o_cursor_show && !o_cursor_lit) else $error("cursor on while blank");
  wrap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    two_q && up_q && o_ram_we && !glyph_q && o_ram_addr == LINE1_LAST
    |-> ap_q == LINE2_FIRST) else $error("line wrap missed");
  read_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_strobe && i_read && i_cmd_or_data_sel && dl_q && up_q && !glyph_q && !two_q &&
    ap_q != ONE_LINE_LAST |=> o_address_pointer == $past(ap_q) + 7'h01)
    else $error("read did not step pointer");
  // Last busy cycle of a command; its effects show one cycle later
  sequence exec_cmd_s;
    st_q == CLIE_BUSY && cnt_q >= EXEC_CYCLES - 1 && !is_data_q;
  endsequence
  // Address set commands pick the target RAM and load the pointer
  glyph_addr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    exec_cmd_s ##0 (cmd_q[7:6] == 2'b01) |=> o_ram_glyph && !o_address_pointer[6])
    else $error("glyph address not set");
  char_addr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    exec_cmd_s ##0 (cmd_q[7]) |=> !o_ram_glyph && o_address_pointer == $past(cmd_q[6:0]))
    else $error("char address not set");
  // Mode commands land in the cycle busy falls
  panel_ctrl_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    exec_cmd_s ##0 (cmd_q[7:3] == 5'b00001) |=> o_panel_on == $past(cmd_q[2]))
    else $error("panel control missed");
  entry_mode_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    exec_cmd_s ##0 (cmd_q[7:2] == 6'b000001) |=>
    up_q == $past(cmd_q[1]) && pan_en_q == $past(cmd_q[0]))
    else $error("entry mode missed");
  duty_code_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    exec_cmd_s ##0 (cmd_q[7:5] == 3'b001 && cmd_q[3]) |=> o_duty == CLIE_DUTY_16)
    else $error("two-line duty wrong");
  pan_keeps_ptr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    exec_cmd_s ##0 (cmd_q[7:3] == 5'b00011) |=> o_address_pointer == $past(ap_q) &&
    o_pan_offset != $past(pan_q)) else $error("pan moved pointer");
  // Host side: half transfers, refused writes, prefetch timing
  first_nibble_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_strobe && !i_read && st_q == CLIE_IDLE && !dl_q && !nib_q |=> !o_busy_flag)
    else $error("busy after first nibble");
  write_refused_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_strobe && !i_read && st_q == CLIE_BUSY |=> $stable(cmd_q) && $stable(dat_q))
    else $error("write taken while busy");
  prefetch_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    fetch2_q |=> pre_q == $past(i_ram_rdata)) else $error("prefetch not loaded");
endmodule
`default_nettype wire

// >>> tb/clie_ram_model.sv
// Synchronous character and glyph RAM behind the executor
`timescale 1ns/1ps
`default_nettype none
module clie_ram_model (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic i_glyph,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_q [0:255];
  // Known fill so an unwritten read hides as zero only at index A5
  initial begin
    for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'hA5;
  end
  // ==========
  // One-cycle read; write lands in the selected RAM
  always @(posedge i_clk) begin
    if (i_we) mem_q[{i_glyph, i_addr}] <= i_wdata;
    o_rdata <= mem_q[{i_glyph, i_addr}];
  end
endmodule
`default_nettype wire

// >>> tb/test_clie_exec.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module test_clie_exec;
  import clie_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, strb = 1'b0, sel = 1'b0, rd = 1'b0, nib = 1'b0;
  logic [7:0] bus = 8'h00, rdat, obus, wdat, d, mem [0:127];
  logic oe, busy, pon, cshow, lit, bw, we, gl, p;
  logic [6:0] ptr, raddr, a, e;
  logic [5:0] pan, g;
  logic [1:0] duty;
  logic [7:0] expq [$];
  logic [7:0] ent [4] = '{8'h06, 8'h07, 8'h05, 8'h04};
  int n_fail = 0, compares = 0, n;
  always #12.5 i_clk = ~i_clk;
  clie_exec #(.EXEC_CYCLES(8), .FLASH_CYCLES(16)) DUT (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_strobe(strb), .i_cmd_or_data_sel(sel), .i_read(rd), .i_bus(bus), .o_bus(obus),
    .o_bus_oe(oe), .o_busy_flag(busy), .o_address_pointer(ptr), .o_panel_on(pon),
    .o_cursor_show(cshow), .o_cursor_lit(lit), .o_pan_offset(pan), .o_bus_width_sel(bw),
    .o_duty(duty), .o_ram_we(we), .o_ram_glyph(gl), .o_ram_addr(raddr),
    .o_ram_wdata(wdat), .i_ram_rdata(rdat));
  clie_ram_model ram (.i_clk(i_clk), .i_we(we), .i_glyph(gl), .i_addr(raddr),
    .i_wdata(wdat), .o_rdata(rdat));
  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] gv, input logic [7:0] ev);
    compares++;
    if (gv !== ev) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, gv, ev);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One strobe; the released bus shows the inverse so stale data cannot pass
  task automatic xfer(input logic s, input logic r, input logic [7:0] v);
    @(posedge i_clk);
    #1 strb = 1'b1;
    sel = s;
    rd = r;
    bus = v;
    @(posedge i_clk);
    #1 strb = 1'b0;
    bus = ~v;
  endtask
  // Write a byte, upper nibble first in narrow mode, then poll busy
  task automatic put(input logic s, input logic [7:0] v);
    int k;
    xfer(s, 1'b0, nib ? {v[7:4], 4'h0} : v);
    if (nib) xfer(s, 1'b0, {v[3:0], 4'h0});
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge i_clk);
    chk({7'h0, busy}, 8'h00);
  endtask
  // Read a byte; expectation noted before the strobe
  task automatic get(input logic s, input logic [7:0] v);
    expq.push_back(v);
    xfer(s, 1'b1, 8'h00);
    if (nib) begin
      expq.push_back({v[3:0], 4'h0});
      xfer(s, 1'b1, 8'h00);
    end
    repeat (4) @(posedge i_clk);
  endtask
  // Read monitor: oldest note against each presented byte
  always @(negedge i_clk) begin
    if (oe === 1'b1 && expq.size() == 0) begin
      n_fail++;
      $display("wrong value at %0t: read with no expectation", $time);
    end else if (oe === 1'b1) begin
      chk(obus, expq.pop_front());
    end
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(71095));
    repeat (3) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    chk({bw, pon, cshow, busy, oe, duty, 1'b0}, 8'h80);
    for (int i = 0; i < 8; i++) begin
      put(1'b0, 8'h08 | 8'(i));
      chk({6'h0, pon, cshow}, {6'h0, i[2], i[2] & i[1]});
    end
    for (int i = 0; i < 2; i++) begin
      put(1'b0, i ? 8'h0C : 8'h0D);
      p = lit;
      n = 0;
      repeat (64) begin
        @(negedge i_clk);
        n += int'(lit !== p);
        p = lit;
      end
      chk({7'h0, i ? n == 0 : n >= 3 && n <= 4}, 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      put(1'b0, 8'h30 | 8'(i << 2));
      chk({6'h0, duty}, i > 1 ? 8'h02 : 8'(i));
    end
    put(1'b0, 8'hA7);
    put(1'b0, 8'h14);
    get(1'b0, 8'h40);
    put(1'b0, 8'hA7);
    put(1'b1, 8'h5A);
    get(1'b0, 8'h40);
    put(1'b0, 8'h30);
    a = 7'($urandom % 32) + 7'h08;
    e = a;
    put(1'b0, {1'b1, a});
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      put(1'b0, ent[i]);
      put(1'b1, d);
      mem[e] = d;
      e = ent[i][1] ? e + 7'h01 : e - 7'h01;
      get(1'b0, {1'b0, e});
      chk({2'h0, pan}, {7'h0, i == 1});
    end
    put(1'b0, 8'h07);
    put(1'b0, {1'b1, a});
    get(1'b1, mem[a]);
    put(1'b0, 8'h14);
    get(1'b1, mem[a + 7'h02]);
    e = a + 7'h03;
    chk({2'h0, pan}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      put(1'b0, 8'h10 | 8'(i << 2));
      if (i < 2) e = i ? e + 7'h01 : e - 7'h01;
      get(1'b0, {1'b0, e});
      chk({2'h0, pan}, {7'h0, i == 2});
    end
    g = 6'($urandom % 32);
    d = 8'($urandom);
    put(1'b0, {2'b01, g});
    put(1'b1, d);
    put(1'b0, {2'b01, g});
    get(1'b1, d);
    chk({2'h0, pan}, 8'h00);
    xfer(1'b0, 1'b0, 8'h08);
    get(1'b0, {2'b10, g + 6'h01});
    put(1'b0, 8'h0C);
    chk({7'h0, pon}, 8'h00);
    put(1'b0, 8'h20);
    nib = 1'b1;
    chk({7'h0, bw}, 8'h00);
    put(1'b0, {1'b1, a});
    get(1'b0, {1'b0, a});
    put(1'b0, 8'h30);
    nib = 1'b0;
    chk({7'h0, bw}, 8'h01);
    repeat (8) @(posedge i_clk);
    chk(8'(expq.size()), 8'h00);
    end_sim;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    n_fail++;
    end_sim;
  end
endmodule
`default_nettype wire
